// >>> bench/chgsup_host_model.sv
// Host stand-in that writes the option word of the supervisor.
// Assumes the bench calls write() at a falling edge.
`default_nettype none
module chgsup_host_model (
    // Clock
    input  wire logic        clk,
    // Option write port
    output var  logic        optWrite,
    output var  logic [15:0] optData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        optWrite = 1'b0;
        optData  = 16'h0000;
    end
    // One write pulse; the released data lines then show the inverse value.
    // A quiet cycle follows so that back-to-back calls always retoggle the strobe.
    task automatic write(input logic [15:0] d);
        optWrite = 1'b1;
        optData  = d;
        @(negedge clk);
        optWrite = 1'b0;
        optData  = ~d;
        @(negedge clk);
    endtask
endmodule // chgsup_host_model
`default_nettype wire

// >>> bench/chgsup_top_sva.sv
// Checker for the charger supervisor top module.
// Assumes one clock domain, reset sys_rst, and is bound to chgsup_top.
`default_nettype none
module chgsup_top_sva #(
    parameter int unsigned MAX_ON = 199
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clkEn,
    // Inputs
    input wire logic        supplyLowLockout,
    input wire logic        adapterSenseAbove2v4,
    input wire logic        adapterSenseAbove0v6,
    input wire logic        headroomAbove245mv,
    input wire logic        optWrite,
    input wire logic [15:0] optData,
    input wire logic        comparatorInAboveRef,
    input wire logic        bootstrapBelow4v3,
    // Outputs
    input wire logic        adapterGoodNOe,
    input wire logic        comparatorOutOut,
    input wire logic        comparatorOutOe,
    input wire logic        highSideOn,
    input wire logic        lowSideOn,
    input wire logic        chargerLatchedOff,
    input wire logic [1:0]  freqSelect,
    input wire logic [9:0]  hsThresholdMv,
    input wire logic [15:0] chargerOptionWord
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic        q;
    logic        ok;
    logic [15:0] w;
    int unsigned hsRun_r;
    int unsigned hsRun_nxt;
    assign q  = !supplyLowLockout && adapterSenseAbove2v4 && headroomAbove245mv;
    assign ok = !supplyLowLockout && adapterSenseAbove0v6;
    assign w  = chargerOptionWord;
    // Length of the current high-side on-time in enabled cycles.
    always_comb hsRun_nxt = !highSideOn ? 0 : clkEn ? hsRun_r + 1 : hsRun_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) hsRun_r <= 0;
        else hsRun_r <= hsRun_nxt;
    end
    a_opt_taken: assert property (
        clkEn && optWrite && ok |=> w == $past(optData)) else $error("write lost");
    a_opt_refused: assert property (
        clkEn && optWrite && !ok |=> $stable(w)) else $error("write not refused");
    a_ack_lost: assert property (
        clkEn && !q |=> !adapterGoodNOe) else $error("adapter good held");
    a_ack_nodelay: assert property (
        clkEn && q && w[15] |=> adapterGoodNOe) else $error("adapter good late");
    a_ack_delay: assert property (
        clkEn && $rose(q) && !w[15] |=> !adapterGoodNOe [*8]) else $error("delay short");
    a_hs_thresh: assert property (
        hsThresholdMv == 10'h12c + 10'hc8 * {8'h00, w[8:7]}) else $error("threshold");
    a_freq_sel: assert property (
        freqSelect == (!w[9] ? 2'h0 : w[10] ? 2'h2 : 2'h1)) else $error("frequency");
    a_cmp_out: assert property (
        clkEn |=> !comparatorOutOut && comparatorOutOe == !$past(comparatorInAboveRef))
        else $error("comparator pin");
    a_latch_clear: assert property (
        clkEn && !ok |=> !chargerLatchedOff) else $error("latch not cleared");
    a_hs_limit: assert property (
        hsRun_r <= MAX_ON) else $error("high side on too long");
    a_refresh_start: assert property (
        clkEn && bootstrapBelow4v3 && adapterGoodNOe && !chargerLatchedOff
        |=> lowSideOn && !highSideOn) else $error("refresh not started");
    a_gate_excl: assert property (
        !(highSideOn && lowSideOn)) else $error("both gates on");
    a_latch_gate: assert property (
        clkEn && chargerLatchedOff |=> !highSideOn) else $error("switching while latched");
endmodule // chgsup_top_sva
bind chgsup_top chgsup_top_sva #(.MAX_ON(MAX_ON)) chgsup_top_sva_i (.*);
`default_nettype wire

// >>> bench/test_chgsup_top.sv
// Self-checking bench for the charger supervisor top module.
// Assumes the host model and the bound checker are compiled with it.
`default_nettype none
module test_chgsup_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 20;
    logic        clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, supplyLowLockout = 1'b0;
    logic        adapterSenseAbove2v4 = 1'b0, adapterSenseAbove0v6 = 1'b1;
    logic        headroomAbove245mv = 1'b1, bootstrapBelow4v3 = 1'b0, loopDemandOn = 1'b0;
    logic        hsOverDrop = 1'b0, lsOverDrop = 1'b0, comparatorInAboveRef = 1'b0;
    logic        optWrite, adapterGoodNOut, adapterGoodNOe, comparatorOutOut;
    logic        comparatorOutOe, highSideOn, lowSideOn, chargerLatchedOff, comparatorRefHigh;
    logic [1:0]  freqSelect;
    logic [9:0]  hsThresholdMv;
    logic [15:0] optData, chargerOptionWord, d;
    int          fail_count = 0, n_checks = 0, hsRises = 0, n, base;
    chgsup_top #(.DLY_LONG(DLY), .DLY_SHORT(DLY / 2)) chgsup_top_i (.*);
    chgsup_host_model chgsup_host_model_i (.clk(clk), .optWrite(optWrite), .optData(optData));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if ($rose(highSideOn)) hsRises <= hsRises + 1;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Counts falling edges until the chosen output is high, within a limit.
    task automatic waitSig(input bit latch, input int lim, output int cnt);
        cnt = 0;
        while ((latch ? chargerLatchedOff : adapterGoodNOe) !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                fail_count++;
                finish_test();
            end
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        chk(16'(hsThresholdMv), 16'h012c);
        chk(16'(comparatorOutOe), 16'h0001);
        sys_rst = 1'b0;
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            d = 16'(i) << 7 | 16'(i) << 9 | 16'(i & 1) << 4;
            chgsup_host_model_i.write(d);
            chk(chargerOptionWord, d);
            chk(16'(hsThresholdMv), 16'h012c + 16'h00c8 * 16'(i));
            chk(16'(freqSelect), (i & 1) == 0 ? 16'h0 : i > 1 ? 16'h2 : 16'h1);
            chk(16'(comparatorRefHigh), 16'(i & 1));
        end
        for (int i = 0; i < 2; i++) begin
            supplyLowLockout = (i == 0);
            adapterSenseAbove0v6 = (i == 0);
            chgsup_host_model_i.write(16'h8000);
            chk(chargerOptionWord, d);
        end
        supplyLowLockout = 1'b0;
        adapterSenseAbove0v6 = 1'b1;
        adapterSenseAbove2v4 = 1'b1;
        waitSig(1'b0, 100, n);
        chk(16'(n), 16'(DLY + 1));
        chk(16'(adapterGoodNOut), 16'h0000);
        for (int c = 0; c < 3; c++) begin
            supplyLowLockout = (c == 0);
            adapterSenseAbove2v4 = (c != 1);
            headroomAbove245mv = (c != 2);
            @(negedge clk);
            chk(16'(adapterGoodNOe), 16'h0000);
            supplyLowLockout = 1'b0;
            adapterSenseAbove2v4 = 1'b1;
            headroomAbove245mv = 1'b1;
            waitSig(1'b0, 100, n);
            chk(16'(n), 16'(DLY + 1));
        end
        adapterSenseAbove2v4 = 1'b0;
        chgsup_host_model_i.write(16'h8000);
        adapterSenseAbove2v4 = 1'b1;
        @(negedge clk);
        chk(16'(adapterGoodNOe), 16'h0001);
        for (int v = 0; v < 2; v++) begin
            comparatorInAboveRef = v[0];
            @(negedge clk);
            chk(16'({comparatorOutOe, comparatorOutOut}), v ? 16'h0 : 16'h2);
        end
        loopDemandOn = 1'b1;
        repeat (5) @(negedge clk);
        bootstrapBelow4v3 = 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(lowSideOn), 16'h0001);
        bootstrapBelow4v3 = 1'b0;
        headroomAbove245mv = 1'b0;
        hsOverDrop = 1'b1;
        repeat (2) @(negedge clk);
        base = hsRises;
        headroomAbove245mv = 1'b1;
        waitSig(1'b1, 3000, n);
        chk(16'(hsRises - base), 16'h0007);
        @(negedge clk);
        chk(16'(highSideOn), 16'h0000);
        adapterSenseAbove0v6 = 1'b0;
        @(negedge clk);
        chk(16'(chargerLatchedOff), 16'h0000);
        adapterSenseAbove0v6 = 1'b1;
        clkEn = 1'b0;
        chgsup_host_model_i.write(16'h0010);
        chk(chargerOptionWord, 16'h8000);
        clkEn = 1'b1;
        chgsup_host_model_i.write(16'h0010);
        chk(chargerOptionWord, 16'h0010);
        chk(16'(comparatorRefHigh), 16'h0001);
        finish_test();
    end
endmodule // test_chgsup_top
`default_nettype wire

// >>> hw/chgsup_short_cnt.sv
// One short-event counter with post-turn-on blanking.
// Assumes switch-on and comparator levels synchronous to clk.
`default_nettype none

module chgsup_short_cnt #(
    parameter int unsigned BLANK = chgsup_pkg::BLANK_CYC,
    parameter int unsigned LIMIT = chgsup_pkg::SHORT_LIMIT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // Control
    input  wire logic clear,
    input  wire logic switchOn,
    input  wire logic overDrop,
    // Status
    output var  logic limitHit
);
    logic [7:0] blankCnt_r, blankCnt_nxt;
    logic [3:0] evCnt_r, evCnt_nxt;
    logic       counted_r, counted_nxt;

    always_comb begin
        blankCnt_nxt = blankCnt_r;
        evCnt_nxt    = evCnt_r;
        counted_nxt  = counted_r;
        if (!switchOn) begin
            blankCnt_nxt = 8'h00;
            counted_nxt  = 1'b0;
        end else if (blankCnt_r < 8'(BLANK)) begin
            blankCnt_nxt = blankCnt_r + 8'h01;
        end else if (overDrop && !counted_r) begin
            counted_nxt = 1'b1;
            if (evCnt_r < 4'(LIMIT)) begin
                evCnt_nxt = evCnt_r + 4'h1;
            end
        end
        if (clear) begin
            evCnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blankCnt_r <= 8'h00;
            evCnt_r    <= 4'h0;
            counted_r  <= 1'b0;
        end else if (clkEn) begin
            blankCnt_r <= blankCnt_nxt;
            evCnt_r    <= evCnt_nxt;
            counted_r  <= counted_nxt;
        end
    end

    assign limitHit = (evCnt_r >= 4'(LIMIT));
endmodule // chgsup_short_cnt

`default_nettype wire

// >>> hw/chgsup_top.sv
// Supervisory logic of a buck charger: adapter-good, option word,
// short latch-off, bootstrap refresh and comparator output.
// Assumes analog comparators deliver clean levels synchronous to clk.
`default_nettype none

module chgsup_top #(
    parameter bit          SHORT_VARIANT = 1'b0,
    parameter int unsigned DLY_LONG      = chgsup_pkg::DELAY_LONG_CYC,
    parameter int unsigned DLY_SHORT     = chgsup_pkg::DELAY_SHORT_CYC,
    parameter int unsigned PERIOD        = chgsup_pkg::PERIOD_CYC,
    parameter int unsigned MAX_ON        = chgsup_pkg::MAX_ON_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // Supply qualification levels
    input  wire logic        supplyLowLockout,
    input  wire logic        adapterSenseAbove2v4,
    input  wire logic        adapterSenseAbove0v6,
    input  wire logic        headroomAbove245mv,
    // Option word write from the serial host
    input  wire logic        optWrite,
    input  wire logic [15:0] optData,
    // Power stage sensing
    input  wire logic        bootstrapBelow4v3,
    input  wire logic        loopDemandOn,
    input  wire logic        hsOverDrop,
    input  wire logic        lsOverDrop,
    input  wire logic        comparatorInAboveRef,
    // Adapter-good open-drain pin
    output var  logic        adapterGoodNOut,
    output var  logic        adapterGoodNOe,
    // Comparator open-drain pin
    output var  logic        comparatorOutOut,
    output var  logic        comparatorOutOe,
    // Power stage controls
    output var  logic        highSideOn,
    output var  logic        lowSideOn,
    output var  logic        chargerLatchedOff,
    output var  logic [1:0]  freqSelect,
    output var  logic [9:0]  hsThresholdMv,
    output var  logic        comparatorRefHigh,
    output var  logic [15:0] chargerOptionWord
);
    localparam int unsigned DLY = SHORT_VARIANT ? DLY_SHORT : DLY_LONG;

    logic        qualAll, qualBus;
    logic [27:0] dlyCnt_r, dlyCnt_nxt;
    logic        acGood_r, acGood_nxt;
    logic [15:0] opt_r, opt_nxt;
    logic        latch_r, latch_nxt;
    logic [7:0]  perCnt_r, perCnt_nxt;
    logic [7:0]  onCnt_r, onCnt_nxt;
    chgsup_pkg::chgsup_pwm_t pwmSt_r, pwmSt_nxt;
    logic        hsHit, lsHit;
    logic [1:0]  fsel_nxt;
    logic [9:0]  hsTh_nxt;

    assign qualAll = !supplyLowLockout && adapterSenseAbove2v4 && headroomAbove245mv;
    // The serial path and the latch release share one condition.
    assign qualBus = !supplyLowLockout && adapterSenseAbove0v6;

    // Adapter-good qualification and deglitch.
    // Losing any condition clears the count, so a bouncing adapter must
    // stay qualified for the whole delay before the pin is pulled low.
    always_comb begin
        dlyCnt_nxt = dlyCnt_r;
        acGood_nxt = acGood_r;
        if (!qualAll) begin
            dlyCnt_nxt = 28'h0000000;
            acGood_nxt = 1'b0;
        end else if (opt_r[chgsup_pkg::OPT_ACDLY_BIT]) begin
            acGood_nxt = 1'b1;
        end else if (dlyCnt_r >= 28'(DLY)) begin
            acGood_nxt = 1'b1;
        end else begin
            dlyCnt_nxt = dlyCnt_r + 28'h0000001;
        end
    end

    // Option word written only while the serial path is enabled; otherwise it keeps its value.
    always_comb begin
        opt_nxt = opt_r;
        if (optWrite && qualBus) begin
            opt_nxt = optData;
        end
        // Decodes follow the incoming word so they change in the same cycle.
        fsel_nxt = chgsup_pkg::FREQ_NOM;
        if (opt_nxt[chgsup_pkg::OPT_FEN_BIT]) begin
            fsel_nxt = opt_nxt[chgsup_pkg::OPT_FDIR_BIT] ? chgsup_pkg::FREQ_HIGH
                                                         : chgsup_pkg::FREQ_LOW;
        end
        unique case (opt_nxt[chgsup_pkg::OPT_HSTH_LSB +: 2])
            2'b00: hsTh_nxt = chgsup_pkg::HS_TH_MV0;
            2'b01: hsTh_nxt = chgsup_pkg::HS_TH_MV1;
            2'b10: hsTh_nxt = chgsup_pkg::HS_TH_MV2;
            2'b11: hsTh_nxt = chgsup_pkg::HS_TH_MV3;
        endcase
    end

    // Latch-off after the seventh short on one switch; released only by supply loss.
    // Clearing beats a short seen in the same cycle, and the counters
    // are cleared by the same condition so the count starts afresh.
    always_comb begin
        latch_nxt = latch_r;
        if (!qualBus) begin
            latch_nxt = 1'b0;
        end else if (hsHit || lsHit) begin
            latch_nxt = 1'b1;
        end
    end

    // Each switch has its own counter; either one reaching the limit latches.
    // The low-side comparator threshold is fixed in the analog front end.
    chgsup_short_cnt uHsCnt (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .clear    (!qualBus),
        .switchOn (highSideOn),
        .overDrop (hsOverDrop),
        .limitHit (hsHit)
    );
    chgsup_short_cnt uLsCnt (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .clear    (!qualBus),
        .switchOn (lowSideOn),
        .overDrop (lsOverDrop),
        .limitHit (lsHit)
    );

    // Switching period with bootstrap refresh and duty ceiling.
    always_comb begin
        perCnt_nxt = (perCnt_r >= 8'(PERIOD - 1)) ? 8'h00 : perCnt_r + 8'h01;
        onCnt_nxt  = onCnt_r;
        pwmSt_nxt  = pwmSt_r;
        if (latch_r || !acGood_r) begin
            pwmSt_nxt = chgsup_pkg::PWM_OFF;
            onCnt_nxt = 8'h00;
        end else begin
            unique case (pwmSt_r)
                chgsup_pkg::PWM_OFF: begin
                    if (bootstrapBelow4v3) begin
                        pwmSt_nxt = chgsup_pkg::PWM_REFRESH;
                    end else if (loopDemandOn && perCnt_nxt == 8'h00) begin
                        pwmSt_nxt = chgsup_pkg::PWM_HIGH;
                        onCnt_nxt = 8'h00;
                    end
                end
                chgsup_pkg::PWM_HIGH: begin
                    // The on-time ceiling forces a refresh even at full demand.
                    onCnt_nxt = onCnt_r + 8'h01;
                    if (bootstrapBelow4v3 || onCnt_r >= 8'(MAX_ON - 1)) begin
                        pwmSt_nxt = chgsup_pkg::PWM_REFRESH;
                    end else if (!loopDemandOn) begin
                        pwmSt_nxt = chgsup_pkg::PWM_OFF;
                    end
                end
                chgsup_pkg::PWM_REFRESH: begin
                    // Refresh runs to the period wrap, then goes straight back on under
                    // full demand, so only one cycle per period is lost to it.
                    if (perCnt_nxt == 8'h00 && !bootstrapBelow4v3) begin
                        onCnt_nxt = 8'h00;
                        pwmSt_nxt = loopDemandOn ? chgsup_pkg::PWM_HIGH
                                                 : chgsup_pkg::PWM_OFF;
                    end
                end
                default: pwmSt_nxt = chgsup_pkg::PWM_OFF;
            endcase
        end
    end

    // Every output is taken from a flip-flop so the pins cannot glitch.
    // The enable freezes the whole block, counters and pins alike.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dlyCnt_r          <= 28'h0000000;
            acGood_r          <= 1'b0;
            opt_r             <= chgsup_pkg::OPT_RESET;
            latch_r           <= 1'b0;
            perCnt_r          <= 8'h00;
            onCnt_r           <= 8'h00;
            pwmSt_r           <= chgsup_pkg::PWM_OFF;
            adapterGoodNOut   <= 1'b0;
            adapterGoodNOe    <= 1'b0;
            comparatorOutOut  <= 1'b0;
            comparatorOutOe   <= 1'b1;
            highSideOn        <= 1'b0;
            lowSideOn         <= 1'b0;
            chargerLatchedOff <= 1'b0;
            freqSelect        <= chgsup_pkg::FREQ_NOM;
            hsThresholdMv     <= chgsup_pkg::HS_TH_MV0;
            comparatorRefHigh <= 1'b0;
            chargerOptionWord <= chgsup_pkg::OPT_RESET;
        end else if (clkEn) begin
            dlyCnt_r          <= dlyCnt_nxt;
            acGood_r          <= acGood_nxt;
            opt_r             <= opt_nxt;
            latch_r           <= latch_nxt;
            perCnt_r          <= perCnt_nxt;
            onCnt_r           <= onCnt_nxt;
            pwmSt_r           <= pwmSt_nxt;
            adapterGoodNOut   <= 1'b0;
            adapterGoodNOe    <= acGood_nxt;
            comparatorOutOut  <= 1'b0;
            comparatorOutOe   <= !comparatorInAboveRef;
            highSideOn        <= (pwmSt_nxt == chgsup_pkg::PWM_HIGH);
            lowSideOn         <= (pwmSt_nxt == chgsup_pkg::PWM_REFRESH);
            chargerLatchedOff <= latch_nxt;
            freqSelect        <= fsel_nxt;
            hsThresholdMv     <= hsTh_nxt;
            comparatorRefHigh <= opt_nxt[chgsup_pkg::OPT_CREF_BIT];
            chargerOptionWord <= opt_nxt;
        end
    end
endmodule // chgsup_top

`default_nettype wire

// >>> inc/chgsup_pkg.sv
// Constants for the charger supervisor logic.
// Assumes analog comparator results arrive as synchronous digital levels.
//
// How it works
// - Adapter-good only with supply, sense, headroom valid
// - Default deglitch delay before adapter-good asserts
// - Option bit 15 removes adapter-good delay
// - Option writes accepted only when supply qualified
// - Low bootstrap voltage starts low-side refresh cycle
// - Refresh limits high-side duty to 99.5 percent
// - Option bit 9 enables frequency adjustment
// - Option bit 10 picks frequency direction
// - Seventh short event on one switch latches charger off
// - Latch clears on lockout or low sense
// - Low-side short threshold fixed at 110 mV
// - Bits 8:7 select high-side short threshold
// - Short sampled only after blanking interval
// - Comparator output released high, driven low below
`default_nettype none

package chgsup_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned DELAY_LONG_MS = 1300;
    localparam int unsigned DELAY_SHORT_US = 1200;
    localparam int unsigned DELAY_LONG_CYC  = DELAY_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned DELAY_SHORT_CYC = DELAY_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DUTY_PERMILLE = 995;
    localparam int unsigned PERIOD_CYC    = 200;
    localparam int unsigned MAX_ON_CYC    = PERIOD_CYC * DUTY_PERMILLE / 1000;
    localparam int unsigned BLANK_CYC     = 8;
    localparam int unsigned SHORT_LIMIT   = 7;
    localparam int unsigned FREQ_ADJ_PCT  = 18;
    localparam int unsigned LS_SHORT_MV   = 110;
    localparam logic [15:0] OPT_RESET     = 16'h0000;
    localparam int unsigned OPT_ACDLY_BIT = 15;
    localparam int unsigned OPT_FDIR_BIT  = 10;
    localparam int unsigned OPT_FEN_BIT   = 9;
    localparam int unsigned OPT_HSTH_LSB  = 7;
    localparam int unsigned OPT_CREF_BIT  = 4;
    localparam logic [9:0] HS_TH_MV0 = 10'h12c;
    localparam logic [9:0] HS_TH_MV1 = 10'h1f4;
    localparam logic [9:0] HS_TH_MV2 = 10'h2bc;
    localparam logic [9:0] HS_TH_MV3 = 10'h384;
    localparam logic [1:0] FREQ_NOM  = 2'h0;
    localparam logic [1:0] FREQ_LOW  = 2'h1;
    localparam logic [1:0] FREQ_HIGH = 2'h2;

    typedef enum logic [1:0] {
        PWM_OFF     = 2'b00,
        PWM_HIGH    = 2'b01,
        PWM_REFRESH = 2'b10
    } chgsup_pwm_t;
endpackage

`default_nettype wire
